// *** verilog/aslm_pkg.sv ***
package aslm_pkg;

    // ------------------------------------------------------------
    // register port geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [11:0] ADR_SUMMARY = 12'h2c0;
    localparam logic [11:0] ADR_FLAGS = 12'h2c1;
    localparam logic [11:0] ADR_MASK = 12'h2c2;
    localparam logic [11:0] ADR_LANE = 12'h2c4;
    localparam logic [11:0] ADR_IRQ_STAT = 12'h2d0;
    localparam logic [11:0] ADR_IRQ_CLR = 12'h2d1;
    localparam logic [11:0] ADR_IRQ_EN = 12'h2d2;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int BIT_CLK = 0;
    localparam int BIT_RSV1 = 1;
    localparam int BIT_REALIGN = 2;
    localparam int BIT_LINK = 3;
    localparam int BIT_PLL = 4;
    localparam int BIT_FIFO = 5;
    localparam int BIT_SUMMARY = 0;
    localparam logic [7:0] FLAGS_RST = 8'h3f;
    localparam logic [7:0] MASK_RST = 8'h3f;
    localparam logic [7:0] LANE_RST = 8'hff;
    localparam logic [7:0] FLAGS_LIVE = 8'h3f;
    localparam logic [7:0] SUMMARY_SRC = 8'h3d;
    localparam logic [7:0] ZERO8 = 8'h00;
    localparam logic [7:0] ONES8 = 8'hff;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] rsv_hi;
        logic lane_fifo_flag;
        logic serdes_pll_unlock_flag;
        logic link_state_flag;
        logic clock_realign_flag;
        logic rsv_lo;
        logic divider_mismatch_flag;
    } aslm_flags_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [7:0] wdata;
    } aslm_req_t;

endpackage : aslm_pkg

// *** verilog/aslm_top.sv ***
// Functional notes
// (RULE_01) pll unlock flag, bit 4, sets while serializer pll unlocked
// (RULE_02) 8b/10b: link flag bit 3 sets if enabled, not encoding data
// (RULE_03) 64b/66b: link flag sets on startup and any realignment
// (RULE_04) realign flag bit 2 sets when sysref realigns internal clocks
// (RULE_05) divider mismatch flag bit 0 sets when pair dividers differ
// (RULE_06) flags are sticky; write one clears, write zero keeps
// (RULE_07) reset or soft reset sets all flags incl bit 1; 7:6 read 0
// (RULE_08) flags except clock flag undefined until link enabled; clear after
// (RULE_09) a set mask bit keeps its flag out of summary alarm
// (RULE_10) mask resets to 0x3f, all sources masked
// (RULE_11) software writes reserved mask bits at their reset values
// (RULE_12) 8-bit per-lane fifo alarm register resets to 0xff
// (RULE_13) fifo flag bit 5 sets on any lane fifo over/underflow
// (RULE_14) summary alarm bit high while any unmasked flag set
// (RULE_15) lane bit i sets on lane i fault; write one clears
// (RULE_16) clearing fifo flag also clears all lane bits
// (RULE_17) set wins over a clear in the same cycle
`timescale 1ns/1ps
module aslm_top #(
    parameter int LANES = 8,
    parameter int DIV_W = 4
) (
    // clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    input wire logic I_SOFT_RST,
    // register port
    input wire logic [aslm_pkg::ADDR_W-1:0] I_ADDR,
    input wire logic [aslm_pkg::DATA_W-1:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [aslm_pkg::DATA_W-1:0] O_RDATA,
    // link and clock status from other domains
    input wire logic I_PLL_LOCKED,
    input wire logic I_LINK_ENABLE,
    input wire logic I_DATA_ENCODING_STATE,
    input wire logic I_MODE_64B66B,
    input wire logic I_LINK_STARTUP,
    input wire logic I_LINK_REALIGN,
    input wire logic I_SYSREF_REALIGN,
    input wire logic [DIV_W-1:0] I_DIV_AB,
    input wire logic [DIV_W-1:0] I_DIV_CD,
    input wire logic [LANES-1:0] I_LANE_FIFO_ERR,
    // alarm outputs
    output logic O_ALARM,
    output logic O_IRQ
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    localparam int SYNC_W = 7 + 2 * DIV_W + LANES;
    logic [SYNC_W-1:0] sync_a_r;
    logic [SYNC_W-1:0] sync_b_r;
    logic pll_locked_s;
    logic link_en_s;
    logic data_encoding_state_s;
    logic mode64_s;
    logic startup_s;
    logic link_realign_s;
    logic sysref_s;
    logic [DIV_W-1:0] div_ab_s;
    logic [DIV_W-1:0] div_cd_s;
    logic [LANES-1:0] lane_err_s;

    // two flops; only the second stage is read by logic
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            sync_a_r <= '0;
            sync_b_r <= '0;
        end
        else
        begin
            sync_a_r <= {I_PLL_LOCKED, I_LINK_ENABLE, I_DATA_ENCODING_STATE,
                I_MODE_64B66B, I_LINK_STARTUP, I_LINK_REALIGN,
                I_SYSREF_REALIGN, I_DIV_AB, I_DIV_CD, I_LANE_FIFO_ERR};
            sync_b_r <= sync_a_r;
        end
    end

    assign {pll_locked_s, link_en_s, data_encoding_state_s, mode64_s, startup_s,
        link_realign_s, sysref_s, div_ab_s, div_cd_s, lane_err_s} = sync_b_r;

    // ------------------------------------------------------------
    // register port decode
    // ------------------------------------------------------------
    aslm_pkg::aslm_req_t req;
    assign req = '{wr: I_WR, rd: I_RD, addr: I_ADDR, wdata: I_WDATA};

    logic wr_flags;
    logic wr_mask;
    logic wr_lane;
    logic wr_irq_clr;
    logic wr_irq_en;
    assign wr_flags = req.wr && (req.addr == aslm_pkg::ADR_FLAGS);
    assign wr_mask = req.wr && (req.addr == aslm_pkg::ADR_MASK);
    assign wr_lane = req.wr && (req.addr == aslm_pkg::ADR_LANE);
    assign wr_irq_clr = req.wr && (req.addr == aslm_pkg::ADR_IRQ_CLR);
    assign wr_irq_en = req.wr && (req.addr == aslm_pkg::ADR_IRQ_EN);

    // ------------------------------------------------------------
    // alarm set conditions
    // ------------------------------------------------------------
    aslm_pkg::aslm_flags_t set_v;
    logic link_cond;
    logic fifo_clr;

    // no encoding state exists in 64b/66b, so watch startup and realign
    always_comb
    begin
        // (RULE_02) 8b/10b link check
        link_cond = link_en_s && !data_encoding_state_s;
        if (mode64_s)
        begin
            // (RULE_03) 64b/66b link events
            link_cond = link_en_s && (startup_s || link_realign_s);
        end
    end

    // one set bit per flag; reserved bits never set by hardware
    always_comb
    begin
        set_v = '0;
        // (RULE_01) pll unlock condition
        set_v.serdes_pll_unlock_flag = !pll_locked_s;
        set_v.link_state_flag = link_cond;
        // (RULE_04) sysref realignment
        set_v.clock_realign_flag = sysref_s;
        // (RULE_05) divider pair compare
        set_v.divider_mismatch_flag = (div_ab_s != div_cd_s);
        // (RULE_13) any lane fifo fault
        set_v.lane_fifo_flag = |lane_err_s;
    end

    assign fifo_clr = wr_flags && req.wdata[aslm_pkg::BIT_FIFO];

    // ------------------------------------------------------------
    // sticky alarm flags
    // ------------------------------------------------------------
    logic [7:0] flags_r;
    logic [7:0] flags_nxt;

    // (RULE_06) write-one clear, sticky otherwise
    // (RULE_17) set ored in after the clear
    assign flags_nxt = ((flags_r & ~(wr_flags ? req.wdata : aslm_pkg::ZERO8))
        | set_v) & aslm_pkg::FLAGS_LIVE;

    // reset leaves every flag high until software acknowledges it
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
    begin
        if (!I_RST_N)
            flags_r <= aslm_pkg::FLAGS_RST;
        // (RULE_07) soft reset presets flags
        else if (I_SOFT_RST)
            flags_r <= aslm_pkg::FLAGS_RST;
        else
            flags_r <= flags_nxt;
    end

    // ------------------------------------------------------------
    // per-lane fifo flags
    // ------------------------------------------------------------
    logic [LANES-1:0] lane_r;
    logic [LANES-1:0] lane_clr;

    // (RULE_16) fifo flag clear wipes every lane bit
    always_comb
    begin
        lane_clr = '0;
        if (fifo_clr)
            lane_clr = '1;
        else if (wr_lane)
            lane_clr = req.wdata[LANES-1:0];
    end

    // (RULE_12) lane register presets to all ones
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
    begin
        if (!I_RST_N)
            lane_r <= aslm_pkg::LANE_RST[LANES-1:0];
        else if (I_SOFT_RST)
            lane_r <= aslm_pkg::LANE_RST[LANES-1:0];
        else
            // (RULE_15) per-lane set beats clear
            lane_r <= (lane_r & ~lane_clr) | lane_err_s;
    end

    // ------------------------------------------------------------
    // mask and summary alarm
    // ------------------------------------------------------------
    logic [7:0] mask_r;

    // reserved bits are stored as written; software keeps them at reset
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
    begin
        if (!I_RST_N)
            // (RULE_10) all sources masked
            mask_r <= aslm_pkg::MASK_RST;
        else if (I_SOFT_RST)
            mask_r <= aslm_pkg::MASK_RST;
        else if (wr_mask)
            mask_r <= req.wdata;
    end

    // registered, so the alarm trails the flags by one cycle
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
    begin
        if (!I_RST_N)
            O_ALARM <= 1'b0;
        else
            // (RULE_14) summary of unmasked flags
            // (RULE_09) mask gates each source
            O_ALARM <= |(flags_r & ~mask_r & aslm_pkg::SUMMARY_SRC);
    end

    // ------------------------------------------------------------
    // interrupt status, clear and enable
    // ------------------------------------------------------------
    logic [7:0] irq_stat_r;
    logic [7:0] irq_en_r;
    logic [7:0] irq_ev;

    // event is a flag condition seen while its flag is low
    assign irq_ev = set_v & ~flags_r & aslm_pkg::FLAGS_LIVE;
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            irq_stat_r <= aslm_pkg::ZERO8;
            irq_en_r <= aslm_pkg::ZERO8;
            O_IRQ <= 1'b0;
        end
        else
        begin
            irq_stat_r <= (irq_stat_r
                & ~(wr_irq_clr ? req.wdata : aslm_pkg::ZERO8)) | irq_ev;
            if (wr_irq_en)
                irq_en_r <= req.wdata & aslm_pkg::FLAGS_LIVE;
            O_IRQ <= |(irq_stat_r & irq_en_r);
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    logic [7:0] rd_mux;
    // unmapped and write-only addresses read as zero
    always_comb
    begin
        case (req.addr)
            aslm_pkg::ADR_SUMMARY: rd_mux = {7'h00, O_ALARM};
            aslm_pkg::ADR_FLAGS: rd_mux = flags_r;
            aslm_pkg::ADR_MASK: rd_mux = mask_r;
            aslm_pkg::ADR_LANE: rd_mux = 8'(lane_r);
            aslm_pkg::ADR_IRQ_STAT: rd_mux = irq_stat_r;
            aslm_pkg::ADR_IRQ_EN: rd_mux = irq_en_r;
            default: rd_mux = aslm_pkg::ZERO8;
        endcase
    end

    // data stands only in the cycle after the read strobe
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
    begin
        if (!I_RST_N)
            O_RDATA <= aslm_pkg::ZERO8;
        else if (req.rd)
            O_RDATA <= rd_mux;
        else
            O_RDATA <= aslm_pkg::ZERO8;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RST_N || I_SOFT_RST);
    sequence s_fifo_clear;
        fifo_clr && !(|lane_err_s);
    endsequence
    property p_pll;
        !pll_locked_s |=> flags_r[aslm_pkg::BIT_PLL];
    endproperty
    a_pll: assert property (p_pll) else $error("pll flag not set"); // RULE_01
    property p_link8;
        link_en_s && !data_encoding_state_s && !mode64_s
            |=> flags_r[aslm_pkg::BIT_LINK];
    endproperty
    a_link8: assert property (p_link8) else $error("link flag 8b"); // RULE_02
    property p_link64;
        link_en_s && mode64_s && (startup_s || link_realign_s)
            |=> flags_r[aslm_pkg::BIT_LINK];
    endproperty
    a_link64: assert property (p_link64) else $error("link 64b"); // RULE_03
    property p_realign;
        sysref_s |=> flags_r[aslm_pkg::BIT_REALIGN];
    endproperty
    a_realign: assert property (p_realign) else $error("realign"); // RULE_04
    property p_div;
        (div_ab_s != div_cd_s) |=> flags_r[aslm_pkg::BIT_CLK];
    endproperty
    a_div: assert property (p_div) else $error("divider flag"); // RULE_05
    property p_keep;
        flags_r[aslm_pkg::BIT_PLL] && !(wr_flags
            && req.wdata[aslm_pkg::BIT_PLL]) |=> flags_r[aslm_pkg::BIT_PLL];
    endproperty
    a_keep: assert property (p_keep) else $error("flag lost"); // RULE_06
    property p_w1c;
        wr_flags && req.wdata[aslm_pkg::BIT_REALIGN] && !sysref_s
            |=> !flags_r[aslm_pkg::BIT_REALIGN];
    endproperty
    a_w1c: assert property (p_w1c) else $error("clear failed"); // RULE_06
    property p_alarm;
        ##1 O_ALARM == $past(|(flags_r & ~mask_r & aslm_pkg::SUMMARY_SRC));
    endproperty
    a_alarm: assert property (p_alarm) else $error("summary wrong"); // RULE_14
    property p_masked;
        (mask_r[5:0] == 6'h3f) [*2] |-> !O_ALARM;
    endproperty
    a_masked: assert property (p_masked) else $error("mask leak"); // RULE_09
    property p_lane_set;
        (|lane_err_s) |=> ((lane_r & $past(lane_err_s)) == $past(lane_err_s));
    endproperty
    a_lane_set: assert property (p_lane_set) else $error("lane"); // RULE_15
    property p_lane_wipe;
        s_fifo_clear |=> (lane_r == '0) && !flags_r[aslm_pkg::BIT_FIFO];
    endproperty
    a_lane_wipe: assert property (p_lane_wipe) else $error("wipe"); // RULE_16
    property p_set_wins;
        wr_flags && req.wdata[aslm_pkg::BIT_PLL] && !pll_locked_s
            |=> flags_r[aslm_pkg::BIT_PLL];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("no set"); // RULE_17

endmodule : aslm_top

// *** sim/aslm_tb.sv ***
`timescale 1ns/1ps
module testbench;

    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic soft_rst = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic pll_locked = 1'b0;
    logic link_en = 1'b0;
    logic enc = 1'b0;
    logic mode66 = 1'b0;
    logic startup = 1'b0;
    logic realign = 1'b0;
    logic sysref = 1'b0;
    logic [3:0] div_ab = 4'h0;
    logic [3:0] div_cd = 4'h0;
    logic [7:0] lane_err = 8'h00;
    logic alarm;
    logic irq;
    int failures = 0;
    int comparisons = 0;
    int seed = 32'h6f39b513;
    logic [7:0] lv = 8'h00;
    logic [7:0] b = 8'h00;
    int srcs[6] = '{0, 2, 3, 4, 5, 6};

    // 200 MHz system clock
    always #2.5 clk = ~clk;

    aslm_top #(.LANES(8), .DIV_W(4)) i_aslm_top (
        .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_SOFT_RST(soft_rst),
        .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
        .O_RDATA(rdata), .I_PLL_LOCKED(pll_locked),
        .I_LINK_ENABLE(link_en), .I_DATA_ENCODING_STATE(enc),
        .I_MODE_64B66B(mode66), .I_LINK_STARTUP(startup),
        .I_LINK_REALIGN(realign), .I_SYSREF_REALIGN(sysref),
        .I_DIV_AB(div_ab), .I_DIV_CD(div_cd),
        .I_LANE_FIFO_ERR(lane_err), .O_ALARM(alarm), .O_IRQ(irq)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        if (failures == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish

    // four-state compare so an unknown never matches
    task automatic check(input string nm, input logic [7:0] e,
                         input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            failures++;
        end
    endtask : check

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle

    // one-cycle write strobe, always a gap cycle before the next
    task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_wr

    // read data only stands in the cycle after the strobe edge
    task automatic reg_rd(input logic [11:0] a, input logic [7:0] e,
                          input string nm);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 check(nm, e, rdata);
    endtask : reg_rd

    // drive one alarm cause on or off
    task automatic set_cond(input int k, input logic on);
        @(posedge clk);
        case (k)
            0: div_cd <= on ? ~div_ab : div_ab;
            2: sysref <= on;
            3: if (mode66) startup <= on; else enc <= !on;
            4: pll_locked <= !on;
            5: lane_err <= on ? lv : 8'h00;
            default: realign <= on;
        endcase
    endtask : set_cond

    // flag expected from cause k; realign only counts in 64b/66b
    function automatic logic [7:0] flag_of(input int k, input logic m);
        if (k == 6)
            return m ? 8'h08 : 8'h00;
        return 8'h01 << k;
    endfunction : flag_of

    task automatic pulse(input int k);
        set_cond(k, 1'b1);
        idle(1);
        set_cond(k, 1'b0);
        idle(5);
    endtask : pulse

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        lv = 8'($random(seed));
        idle(8);
        rst_n <= 1'b1;
        reg_rd(12'h2c1, 8'h3f, "flags rst");
        // read data must fall back to zero after its single cycle
        idle(1);
        #1 check("rdata stands", 8'h00, rdata);
        reg_rd(12'h2c2, 8'h3f, "mask rst");
        reg_rd(12'h2c4, 8'hff, "lane rst");
        reg_rd(12'h2c0, 8'h00, "summary rst");
        // bring the link up cleanly, then clear the start-up flags
        @(posedge clk);
        pll_locked <= 1'b1;
        link_en <= 1'b1;
        enc <= 1'b1;
        div_ab <= lv[3:0];
        div_cd <= lv[3:0];
        idle(5);
        reg_wr(12'h2c1, 8'hff);
        reg_wr(12'h2c4, 8'hff);
        reg_rd(12'h2c1, 8'h00, "flags clr");
        reg_rd(12'h2c4, 8'h00, "lane clr");
        // every cause in both encodings, random lane patterns
        for (int m = 0; m < 2; m++)
        begin
            @(posedge clk);
            mode66 <= m[0];
            idle(5);
            reg_wr(12'h2c1, 8'hff);
            foreach (srcs[i])
            begin
                lv = 8'($random(seed)) | 8'h11;
                b = flag_of(srcs[i], m[0]);
                pulse(srcs[i]);
                reg_rd(12'h2c1, b, "flags set");
                reg_wr(12'h2c1, 8'h00);
                reg_rd(12'h2c1, b, "flags keep");
                if (srcs[i] == 5)
                begin
                    reg_rd(12'h2c4, lv, "lane set");
                    reg_wr(12'h2c4, lv & 8'h0f);
                    reg_rd(12'h2c4, lv & 8'hf0, "lane w1c");
                end
                reg_wr(12'h2c1, b);
                reg_rd(12'h2c1, 8'h00, "flags w1c");
                reg_rd(12'h2c4, 8'h00, "lane all");
            end
        end
        // clear against a persisting cause
        set_cond(4, 1'b1);
        idle(4);
        reg_wr(12'h2c1, 8'h10);
        reg_rd(12'h2c1, 8'h10, "flag persist");
        set_cond(4, 1'b0);
        idle(4);
        reg_wr(12'h2c1, 8'hff);
        // mask against the summary alarm, one source at a time
        for (int i = 0; i < 5; i++)
        begin
            b = flag_of(srcs[i], 1'b1);
            pulse(srcs[i]);
            reg_wr(12'h2c2, 8'h3f & ~b);
            idle(3);
            check("alarm on", 8'h01, {7'h00, alarm});
            reg_rd(12'h2c0, 8'h01, "summary");
            reg_wr(12'h2c2, 8'h02 | b);
            idle(3);
            check("alarm masked", 8'h00, {7'h00, alarm});
            reg_rd(12'h2c2, 8'h02 | b, "mask rw");
            reg_wr(12'h2c1, b);
            reg_wr(12'h2c2, 8'h02);
            idle(3);
            check("alarm clear", 8'h00, {7'h00, alarm});
            reg_wr(12'h2c2, 8'h3f);
        end
        // interrupt: raise, mask, clear, unmapped places
        reg_wr(12'h2d1, 8'hff);
        reg_wr(12'h2d2, 8'h10);
        reg_rd(12'h2d2, 8'h10, "irq en");
        set_cond(4, 1'b1);
        idle(6);
        check("irq on", 8'h01, {7'h00, irq});
        reg_rd(12'h2d0, 8'h10, "irq stat");
        set_cond(4, 1'b0);
        idle(4);
        reg_wr(12'h2d2, 8'h00);
        idle(2);
        check("irq masked", 8'h00, {7'h00, irq});
        reg_wr(12'h2d2, 8'h10);
        idle(2);
        check("irq again", 8'h01, {7'h00, irq});
        reg_wr(12'h2d1, 8'h10);
        idle(2);
        check("irq clr", 8'h00, {7'h00, irq});
        reg_rd(12'h2d1, 8'h00, "clr wo");
        reg_wr(12'h2c3, 8'hff);
        reg_rd(12'h2c3, 8'h00, "unmapped");
        // soft reset presets flags, mask and lanes
        @(posedge clk);
        soft_rst <= 1'b1;
        @(posedge clk);
        soft_rst <= 1'b0;
        reg_rd(12'h2c1, 8'h3f, "flags soft");
        reg_rd(12'h2c2, 8'h3f, "mask soft");
        reg_rd(12'h2c4, 8'hff, "lane soft");
        // interrupt enable survives a soft reset
        reg_rd(12'h2d2, 8'h10, "irq en soft");
        check("alarm soft", 8'h00, {7'h00, alarm});
        tally_and_finish();
    end

    // watchdog, far beyond the few hundred cycles the run needs
    initial
    begin
        #200000;
        failures++;
        tally_and_finish();
    end

endmodule : testbench
